// ==== rtl/tmr2_pkg.sv ====
// constants and state types for the timer two block
package tmr2_pkg;

  // ------------------------------------------------------------
  // register offsets
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL   = 8'hc8; // timer_two_control
  localparam logic [7:0] ADDR_MODE   = 8'hc9; // timer_two_mode_control
  localparam logic [7:0] ADDR_RCAP_L = 8'hca; // capture_reload_low
  localparam logic [7:0] ADDR_RCAP_H = 8'hcb; // capture_reload_high
  localparam logic [7:0] ADDR_CNT_L  = 8'hcc; // count_low_byte
  localparam logic [7:0] ADDR_CNT_H  = 8'hcd; // count_high_byte

  // ------------------------------------------------------------
  // control register fields
  // ------------------------------------------------------------
  localparam int CTRL_OVF  = 7; // overflow_flag
  localparam int CTRL_EXF  = 6; // external_flag
  localparam int CTRL_RCLK = 5; // receive clock select
  localparam int CTRL_TCLK = 4; // transmit clock select
  localparam int CTRL_EXEN = 3; // external_enable
  localparam int CTRL_RUN  = 2; // run_control
  localparam int CTRL_CT   = 1; // counter_timer_select
  localparam int CTRL_CPRL = 0; // capture_reload_select

  // ------------------------------------------------------------
  // mode register fields
  // ------------------------------------------------------------
  localparam int MODE_HC5  = 7; // hw_clear_ext5
  localparam int MODE_HC2  = 4; // hw_clear_ext2 .. ext5 sit in 4..7
  localparam int MODE_CRST = 3; // capture_reset
  localparam int MODE_OE   = 1; // clock_out_enable
  localparam int MODE_DOWN_COUNT_ENABLE = 0; // down_count_enable

  // ------------------------------------------------------------
  // reset values and timing counts
  // ------------------------------------------------------------
  localparam logic [7:0]  RST_BYTE   = 8'h00;
  localparam logic [15:0] RST_WORD   = 16'h0000;
  localparam logic [15:0] CNT_ONES   = 16'hffff;
  localparam logic [3:0]  DIV_SLOW   = 4'hc; // clocks per tick, speed select 0
  localparam logic [3:0]  DIV_FAST   = 4'h4; // clocks per tick, speed select 1

  // ------------------------------------------------------------
  // block state
  // ------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  ctrl;
    logic [7:0]  mode;
    logic [15:0] cnt;
    logic [15:0] rcap;
    logic [7:0]  rdata;
    logic [3:0]  pre;
    logic        half;
    logic [2:0]  trig_sync;   // [0] first, [1] second, [2] previous
    logic [2:0]  cpin_sync;
    logic        clk_out;
    logic        rx_tick;
    logic        tx_tick;
    logic [3:0]  ext_int;
  } tmr2_state_s;

endpackage

// ==== rtl/tmr2_top.sv ====
// timer two: counter, capture, reload, baud generation and clock out
`timescale 1ns/10ps
`default_nettype none

// Behaviour
// [RULE1] overflow flag sets on rollover, or count equal capture while counting down
// [RULE2] hardware sets overflow flag only with both clock selects zero; software writes freely
// [RULE3] external flag sets on trigger fall or on overflow in down-count mode
// [RULE4] set external or overflow flag raises timer interrupt when enabled
// [RULE5] receive clock select picks timer one or this timer overflow; forces baud mode
// [RULE6] transmit clock select picks timer one or this timer overflow; forces baud mode
// [RULE7] trigger fall captures or reloads only with external enable, outside baud mode
// [RULE8] run control enables counting; cleared holds count bytes
// [RULE9] baud mode advances counter every 2 clocks regardless of counter select
// [RULE10] counter select 0 counts prescaled clock, 1 counts count pin falls
// [RULE11] in baud mode capture select ignored, reload on every overflow
// [RULE12] reload mode reloads on overflow and on enabled trigger fall
// [RULE13] capture mode copies count bytes into capture registers on enabled trigger fall
// [RULE14] capture reset clears counter after capture
// [RULE15] clock out enable switches clock-out function
// [RULE16] down-count enable with trigger level sets direction in auto-reload mode
// [RULE17] capture low and high take count low and high bytes
// [RULE18] capture low and high form reload value low and high bytes
// [RULE19] hw clear bits clear external interrupt 2..5 flags on service entry
// [RULE20] low byte is bits 7..0, high 15..8; up rolls all ones to zero
// [RULE21] down-count mode counts up while trigger high, down while low
module tmr2_top (
  // clock and reset
  input  wire logic       CLOCK_I,
  input  wire logic       RSTN_I,
  // register port
  input  wire logic [7:0] ADDR_I,
  input  wire logic [7:0] WDATA_I,
  input  wire logic       WR_I,
  input  wire logic       RD_I,
  output logic      [7:0] RDATA_O,
  // pins
  input  wire logic       COUNT_PIN_I,
  input  wire logic       TRIGGER_PIN_I,
  output logic            CLOCK_OUT_O,
  output logic            CLOCK_OUT_OE_O,
  // core side
  input  wire logic       CLOCK_SPEED_SELECT_I,
  input  wire logic       TIMER1_OVF_I,
  input  wire logic       TIMER_INT_EN_I,
  output logic            TIMER_IRQ_O,
  output logic            OVERFLOW_FLAG_O,
  output logic            EXTERNAL_FLAG_O,
  output logic            OVERFLOW_O,
  output logic            RX_BAUD_TICK_O,
  output logic            TX_BAUD_TICK_O,
  // external interrupts 2..5
  input  wire logic [3:0] EXT_INT_SET_I,
  input  wire logic [3:0] EXT_INT_ENTRY_I,
  output logic      [3:0] EXT_INT_FLAG_O
);

  // ------------------------------------------------------------
  // state and decoded terms
  // ------------------------------------------------------------
  tmr2_pkg::tmr2_state_s st_r;
  tmr2_pkg::tmr2_state_s st_nxt;
  logic                  baud_mode;
  logic                  down_count_enable_mode;
  logic                  trig_fall;
  logic                  cpin_fall;
  logic                  count_up;
  logic                  tick;
  logic                  up_ovf;
  logic                  dn_ovf;
  logic                  ovf_evt;
  logic                  ext_edge;
  logic                  cap_evt;
  logic                  rld_evt;
  logic [3:0]            div_m1;
  logic                  wr_cnt;

  // address match for a write strobe
  function automatic logic wr_hit(input logic [7:0] a);
    wr_hit = WR_I && (ADDR_I == a);
  endfunction

  // mode and event decode
  always_comb begin
    baud_mode = st_r.ctrl[tmr2_pkg::CTRL_RCLK] | st_r.ctrl[tmr2_pkg::CTRL_TCLK]; // [RULE5] [RULE6]
    down_count_enable_mode = st_r.mode[tmr2_pkg::MODE_DOWN_COUNT_ENABLE] & ~st_r.ctrl[tmr2_pkg::CTRL_CPRL] & ~baud_mode;
    trig_fall = st_r.trig_sync[2] & ~st_r.trig_sync[1];
    cpin_fall = st_r.cpin_sync[2] & ~st_r.cpin_sync[1];
    count_up  = ~down_count_enable_mode | st_r.trig_sync[1]; // [RULE16] [RULE21]
    div_m1    = (CLOCK_SPEED_SELECT_I ? tmr2_pkg::DIV_FAST : tmr2_pkg::DIV_SLOW) - 4'h1;
    // tick source: baud half rate, pin edges, or prescaled clock
    if (!st_r.ctrl[tmr2_pkg::CTRL_RUN]) begin
      tick = 1'b0; // [RULE8]
    end else if (baud_mode) begin
      tick = st_r.half; // [RULE9]
    end else if (st_r.ctrl[tmr2_pkg::CTRL_CT]) begin
      tick = cpin_fall; // [RULE10]
    end else begin
      tick = (st_r.pre == div_m1); // [RULE10]
    end
    up_ovf   = tick & count_up & (st_r.cnt == tmr2_pkg::CNT_ONES); // [RULE20]
    dn_ovf   = tick & ~count_up & (st_r.cnt == st_r.rcap); // [RULE1]
    ovf_evt  = up_ovf | dn_ovf;
    ext_edge = trig_fall & st_r.ctrl[tmr2_pkg::CTRL_EXEN] & ~down_count_enable_mode; // [RULE7]
    cap_evt  = ext_edge & st_r.ctrl[tmr2_pkg::CTRL_CPRL] & ~baud_mode; // [RULE13]
    rld_evt  = ext_edge & ~st_r.ctrl[tmr2_pkg::CTRL_CPRL] & ~baud_mode; // [RULE12]
    wr_cnt   = wr_hit(tmr2_pkg::ADDR_CNT_L) | wr_hit(tmr2_pkg::ADDR_CNT_H);
  end

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    // pin synchronisers and edge history
    st_nxt.trig_sync = {st_r.trig_sync[1], st_r.trig_sync[0], TRIGGER_PIN_I};
    st_nxt.cpin_sync = {st_r.cpin_sync[1], st_r.cpin_sync[0], COUNT_PIN_I};
    // free running prescalers
    st_nxt.half = ~st_r.half;
    st_nxt.pre  = (st_r.pre >= div_m1) ? 4'h0 : st_r.pre + 4'h1;
    // counter advance and overflow handling
    if (up_ovf) begin
      if (baud_mode || !st_r.ctrl[tmr2_pkg::CTRL_CPRL]) begin
        st_nxt.cnt = st_r.rcap; // [RULE11] [RULE12] [RULE18]
      end else begin
        st_nxt.cnt = tmr2_pkg::RST_WORD; // [RULE20]
      end
    end else if (dn_ovf) begin
      st_nxt.cnt = tmr2_pkg::CNT_ONES;
    end else if (tick) begin
      st_nxt.cnt = count_up ? st_r.cnt + 16'h0001 : st_r.cnt - 16'h0001;
    end
    // trigger pin reload
    if (rld_evt) begin
      st_nxt.cnt = st_r.rcap; // [RULE12]
    end
    // software writes to the count bytes override counting
    if (wr_hit(tmr2_pkg::ADDR_CNT_L)) begin
      st_nxt.cnt[7:0] = WDATA_I;
    end
    if (wr_hit(tmr2_pkg::ADDR_CNT_H)) begin
      st_nxt.cnt[15:8] = WDATA_I;
    end
    if (wr_hit(tmr2_pkg::ADDR_RCAP_L)) begin
      st_nxt.rcap[7:0] = WDATA_I;
    end
    if (wr_hit(tmr2_pkg::ADDR_RCAP_H)) begin
      st_nxt.rcap[15:8] = WDATA_I;
    end
    // capture wins over a software write to the capture registers
    if (cap_evt) begin
      st_nxt.rcap = st_r.cnt; // [RULE13] [RULE17]
      if (st_r.mode[tmr2_pkg::MODE_CRST] && !wr_cnt) begin
        st_nxt.cnt = tmr2_pkg::RST_WORD; // [RULE14]
      end
    end
    if (wr_hit(tmr2_pkg::ADDR_MODE)) begin
      st_nxt.mode = WDATA_I;
    end
    // control write first, hardware flag sets win afterwards
    if (wr_hit(tmr2_pkg::ADDR_CTRL)) begin
      st_nxt.ctrl = WDATA_I; // [RULE2]
    end
    if (ovf_evt && !baud_mode) begin
      st_nxt.ctrl[tmr2_pkg::CTRL_OVF] = 1'b1; // [RULE1] [RULE2]
    end
    if (ext_edge || (down_count_enable_mode && ovf_evt)) begin
      st_nxt.ctrl[tmr2_pkg::CTRL_EXF] = 1'b1; // [RULE3]
    end
    // clock out toggles on each overflow while clock out enable is set
    if (ovf_evt && st_r.mode[tmr2_pkg::MODE_OE]) begin
      st_nxt.clk_out = ~st_r.clk_out; // [RULE15]
    end
    // serial port 0 time base selection
    st_nxt.rx_tick = st_r.ctrl[tmr2_pkg::CTRL_RCLK] ? ovf_evt : TIMER1_OVF_I; // [RULE5]
    st_nxt.tx_tick = st_r.ctrl[tmr2_pkg::CTRL_TCLK] ? ovf_evt : TIMER1_OVF_I; // [RULE6]
    // external interrupt flags: set wins over service clear
    st_nxt.ext_int = (st_r.ext_int
                      & ~(EXT_INT_ENTRY_I & st_r.mode[tmr2_pkg::MODE_HC5:tmr2_pkg::MODE_HC2]))
                     | EXT_INT_SET_I; // [RULE19]
    // read data, one cycle after the strobe
    st_nxt.rdata = tmr2_pkg::RST_BYTE;
    if (RD_I) begin
      case (ADDR_I)
        tmr2_pkg::ADDR_CTRL:   st_nxt.rdata = st_r.ctrl;
        tmr2_pkg::ADDR_MODE:   st_nxt.rdata = st_r.mode;
        tmr2_pkg::ADDR_RCAP_L: st_nxt.rdata = st_r.rcap[7:0];
        tmr2_pkg::ADDR_RCAP_H: st_nxt.rdata = st_r.rcap[15:8];
        tmr2_pkg::ADDR_CNT_L:  st_nxt.rdata = st_r.cnt[7:0];
        tmr2_pkg::ADDR_CNT_H:  st_nxt.rdata = st_r.cnt[15:8];
        default:               st_nxt.rdata = tmr2_pkg::RST_BYTE;
      endcase
    end
  end

  // state register
  always_ff @(posedge CLOCK_I) begin
    if (!RSTN_I) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign RDATA_O         = st_r.rdata;
  assign CLOCK_OUT_O     = st_r.clk_out;
  assign CLOCK_OUT_OE_O  = st_r.mode[tmr2_pkg::MODE_OE] & ~st_r.ctrl[tmr2_pkg::CTRL_CT]; // [RULE15]
  assign OVERFLOW_FLAG_O = st_r.ctrl[tmr2_pkg::CTRL_OVF];
  assign EXTERNAL_FLAG_O = st_r.ctrl[tmr2_pkg::CTRL_EXF];
  assign OVERFLOW_O      = ovf_evt;
  assign RX_BAUD_TICK_O  = st_r.rx_tick;
  assign TX_BAUD_TICK_O  = st_r.tx_tick;
  assign EXT_INT_FLAG_O  = st_r.ext_int;
  // interrupt request from either flag
  assign TIMER_IRQ_O     = TIMER_INT_EN_I
                           & (st_r.ctrl[tmr2_pkg::CTRL_EXF] | st_r.ctrl[tmr2_pkg::CTRL_OVF]); // [RULE4]

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (!RSTN_I);

  sequence up_wrap_s;
    up_ovf && !baud_mode && !wr_cnt && !rld_evt;
  endsequence

  sequence baud_pair_s;
    baud_mode && tick ##1 baud_mode && st_r.ctrl[tmr2_pkg::CTRL_RUN]
      && !wr_hit(tmr2_pkg::ADDR_CTRL);
  endsequence

  ovf_flag_set_a: assert property (ovf_evt && !baud_mode |=> OVERFLOW_FLAG_O) // [RULE1]
    else $error("overflow flag not set after overflow");
  ovf_baud_hold_a: assert property (baud_mode && !OVERFLOW_FLAG_O && !wr_hit(tmr2_pkg::ADDR_CTRL)
    |=> !OVERFLOW_FLAG_O) // [RULE2]
    else $error("overflow flag set in baud mode");
  ext_edge_set_a: assert property (ext_edge |=> EXTERNAL_FLAG_O ##0 TIMER_IRQ_O || !TIMER_INT_EN_I) // [RULE3]
    else $error("external flag missing after trigger fall");
  irq_raise_a: assert property (EXTERNAL_FLAG_O && TIMER_INT_EN_I |-> TIMER_IRQ_O) // [RULE4]
    else $error("interrupt not raised by external flag");
  rx_select_a: assert property (st_r.ctrl[tmr2_pkg::CTRL_RCLK] && ovf_evt |=> RX_BAUD_TICK_O) // [RULE5]
    else $error("receive tick missing");
  tx_select_a: assert property (!st_r.ctrl[tmr2_pkg::CTRL_TCLK] |=> TX_BAUD_TICK_O == $past(TIMER1_OVF_I)) // [RULE6]
    else $error("transmit tick not from timer one");
  trig_ignore_a: assert property (!st_r.ctrl[tmr2_pkg::CTRL_EXEN] |-> !cap_evt && !rld_evt) // [RULE7]
    else $error("trigger acted while disabled");
  run_hold_a: assert property (!st_r.ctrl[tmr2_pkg::CTRL_RUN] && !wr_cnt && !ext_edge
    |=> $stable(st_r.cnt)) // [RULE8]
    else $error("count moved while stopped");
  baud_rate_a: assert property (baud_pair_s |-> !tick ##1 tick) // [RULE9]
    else $error("baud tick not every two clocks");
  reload_val_a: assert property (up_wrap_s ##0 (!st_r.ctrl[tmr2_pkg::CTRL_CPRL])
    |=> st_r.cnt == $past(st_r.rcap)) // [RULE12]
    else $error("reload value wrong");
  capture_val_a: assert property (cap_evt |=> st_r.rcap == $past(st_r.cnt)) // [RULE13]
    else $error("capture value wrong");
  cap_reset_a: assert property (cap_evt && st_r.mode[tmr2_pkg::MODE_CRST] && !wr_cnt
    |=> st_r.cnt == tmr2_pkg::RST_WORD) // [RULE14]
    else $error("counter not cleared after capture");
  hw_clear_a: assert property (EXT_INT_ENTRY_I[0] && st_r.mode[tmr2_pkg::MODE_HC2] && !EXT_INT_SET_I[0]
    |=> !EXT_INT_FLAG_O[0]) // [RULE19]
    else $error("external interrupt 2 flag not cleared");

  // ------------------------------------------------------------
  // assertions: counting, flags, selects and read port
  // ------------------------------------------------------------
  // a step that no wrap, write, reload or capture disturbs
  sequence plain_step_s;
    tick && !up_ovf && !dn_ovf && !wr_cnt && !rld_evt && !cap_evt;
  endsequence

  // a down-count underflow left alone by software
  sequence dn_wrap_s;
    dn_ovf && !wr_cnt;
  endsequence

  // upward step adds one
  up_step_a: assert property (plain_step_s ##0 count_up // [RULE20]
    |=> st_r.cnt == $past(st_r.cnt) + 16'h0001)
    else $error("up step wrong");

  // downward step takes one away
  down_step_a: assert property (plain_step_s ##0 !count_up // [RULE16] [RULE21]
    |=> st_r.cnt == $past(st_r.cnt) - 16'h0001)
    else $error("down step wrong");

  // underflow reloads all ones
  dn_wrap_a: assert property (dn_wrap_s // [RULE1]
    |=> st_r.cnt == tmr2_pkg::CNT_ONES)
    else $error("underflow value wrong");

  // underflow also raises the external flag
  dn_ext_a: assert property (dn_wrap_s // [RULE3]
    |=> EXTERNAL_FLAG_O)
    else $error("external flag missing on underflow");

  // capture mode rolls over to zero
  cap_wrap_a: assert property (up_wrap_s ##0 st_r.ctrl[tmr2_pkg::CTRL_CPRL] // [RULE20]
    |=> st_r.cnt == tmr2_pkg::RST_WORD)
    else $error("capture mode wrap not to zero");

  // baud mode reloads on every overflow
  baud_reload_a: assert property (baud_mode && up_ovf && !wr_cnt // [RULE11]
    |=> st_r.cnt == $past(st_r.rcap))
    else $error("baud reload value wrong");

  // no capture and no reload while making baud clocks
  trig_baud_a: assert property (baud_mode // [RULE7]
    |-> !cap_evt && !rld_evt)
    else $error("trigger acted in baud mode");

  // trigger reload loads the count from the capture registers
  trig_reload_a: assert property (rld_evt && !wr_cnt // [RULE12]
    |=> st_r.cnt == $past(st_r.rcap))
    else $error("trigger reload value wrong");

  // stopped counter sees no tick
  run_stop_a: assert property (!st_r.ctrl[tmr2_pkg::CTRL_RUN] // [RULE8]
    |-> !tick)
    else $error("tick while stopped");

  // counter mode ticks on count pin falls only
  pin_tick_a: assert property (st_r.ctrl[tmr2_pkg::CTRL_RUN] && !baud_mode // [RULE10]
    && st_r.ctrl[tmr2_pkg::CTRL_CT] |-> tick == cpin_fall)
    else $error("counter mode tick not from count pin");

  // capture registers hold without capture or write
  cap_keep_a: assert property (!cap_evt && !wr_hit(tmr2_pkg::ADDR_RCAP_L) // [RULE17]
    && !wr_hit(tmr2_pkg::ADDR_RCAP_H) |=> $stable(st_r.rcap))
    else $error("capture registers changed");

  // transmit time base from this timer
  tx_self_a: assert property (st_r.ctrl[tmr2_pkg::CTRL_TCLK] && ovf_evt // [RULE6]
    |=> TX_BAUD_TICK_O)
    else $error("transmit tick missing");

  // receive time base from timer one
  rx_timer1_a: assert property (!st_r.ctrl[tmr2_pkg::CTRL_RCLK] // [RULE5]
    |=> RX_BAUD_TICK_O == $past(TIMER1_OVF_I))
    else $error("receive tick not from timer one");

  // clock out toggles on overflow while enabled
  clk_out_a: assert property (ovf_evt && st_r.mode[tmr2_pkg::MODE_OE] // [RULE15]
    |=> CLOCK_OUT_O != $past(CLOCK_OUT_O))
    else $error("clock out did not toggle");

  // flags fall only by a control write
  ext_hold_a: assert property (EXTERNAL_FLAG_O && !wr_hit(tmr2_pkg::ADDR_CTRL) // [RULE3]
    |=> EXTERNAL_FLAG_O)
    else $error("external flag dropped");

  ovf_hold_a: assert property (OVERFLOW_FLAG_O && !wr_hit(tmr2_pkg::ADDR_CTRL) // [RULE2]
    |=> OVERFLOW_FLAG_O)
    else $error("overflow flag dropped");

  // software value lands when no overflow competes
  ovf_sw_a: assert property (wr_hit(tmr2_pkg::ADDR_CTRL) && !ovf_evt // [RULE2]
    |=> OVERFLOW_FLAG_O == $past(WDATA_I[tmr2_pkg::CTRL_OVF]))
    else $error("software write to overflow flag lost");

  // read data stands one cycle, zero otherwise
  rd_idle_a: assert property (!RD_I
    |=> RDATA_O == tmr2_pkg::RST_BYTE)
    else $error("read data not cleared");

  rd_ctrl_a: assert property (RD_I && ADDR_I == tmr2_pkg::ADDR_CTRL
    |=> RDATA_O == $past(st_r.ctrl))
    else $error("control read wrong");

  // per line service clear and hold, interrupts 2..5
  for (genvar i = 0; i < $bits(EXT_INT_FLAG_O); i++) begin : g_hc
    hc_clear_a: assert property (EXT_INT_ENTRY_I[i] && !EXT_INT_SET_I[i] // [RULE19]
      && st_r.mode[tmr2_pkg::MODE_HC2 + i] |=> !EXT_INT_FLAG_O[i])
      else $error("external interrupt flag not cleared");
    hc_keep_a: assert property (EXT_INT_FLAG_O[i] // [RULE19]
      && !st_r.mode[tmr2_pkg::MODE_HC2 + i] |=> EXT_INT_FLAG_O[i])
      else $error("external interrupt flag lost");
  end

endmodule

`default_nettype wire

// ==== sim/tmr2_pins.sv ====
// pin-side model driving the count pin and the trigger pin
`timescale 1ns/10ps
`default_nettype none

module tmr2_pins (
  // clock
  input  wire logic CLOCK_I,
  // pins, pulled high when idle
  output logic      COUNT_PIN_O,
  output logic      TRIGGER_PIN_O
);
  // --------------------------------------------------------------
  // pin pulses
  // --------------------------------------------------------------
  // idle level of both pins
  initial begin
    COUNT_PIN_O   = 1'b1;
    TRIGGER_PIN_O = 1'b1;
  end

  // n falls on one pin, each level held 3 clocks for the synchroniser
  task automatic pulse(input bit trig, input int n);
    repeat (n) begin
      @(posedge CLOCK_I);
      {TRIGGER_PIN_O, COUNT_PIN_O} <= trig ? 2'b01 : 2'b10;
      repeat (3) @(posedge CLOCK_I);
      {TRIGGER_PIN_O, COUNT_PIN_O} <= 2'b11;
      repeat (3) @(posedge CLOCK_I);
    end
  endtask

  // hold the trigger pin at one level, settled through the synchroniser
  task automatic level(input bit v);
    @(posedge CLOCK_I);
    TRIGGER_PIN_O <= v;
    repeat (3) @(posedge CLOCK_I);
  endtask
endmodule
`default_nettype wire

// ==== sim/test_tmr2_top.sv ====
// self-checking bench for the timer two block
`timescale 1ns/10ps
`default_nettype none

module test_tmr2_top;
  logic       clk, rstn, wr_s, rd_s, spd, t1ovf, ien;
  logic [7:0] addr, wdata;
  logic [3:0] eset, eentry;
  wire logic [7:0] rdata;
  wire logic [3:0] eflag;
  wire logic       cpin, tpin, cko, ckoe, irq, ovff, extf, ovf, rxt, txt;
  int         num_errors = 0;
  int         n_compared = 0;
  int         cyc = 0;

  tmr2_top dut (.CLOCK_I(clk), .RSTN_I(rstn), .ADDR_I(addr), .WDATA_I(wdata),
    .WR_I(wr_s), .RD_I(rd_s), .RDATA_O(rdata), .COUNT_PIN_I(cpin),
    .TRIGGER_PIN_I(tpin), .CLOCK_OUT_O(cko), .CLOCK_OUT_OE_O(ckoe),
    .CLOCK_SPEED_SELECT_I(spd), .TIMER1_OVF_I(t1ovf), .TIMER_INT_EN_I(ien),
    .TIMER_IRQ_O(irq), .OVERFLOW_FLAG_O(ovff), .EXTERNAL_FLAG_O(extf),
    .OVERFLOW_O(ovf), .RX_BAUD_TICK_O(rxt), .TX_BAUD_TICK_O(txt),
    .EXT_INT_SET_I(eset), .EXT_INT_ENTRY_I(eentry), .EXT_INT_FLAG_O(eflag));
  tmr2_pins pins (.CLOCK_I(clk), .COUNT_PIN_O(cpin), .TRIGGER_PIN_O(tpin));

  // --------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------
  // clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic cb(input logic seen, input logic exp);
    chk({15'h0000, seen}, {15'h0000, exp});
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr_s  <= 1'b1;
    @(posedge clk);
    wr_s  <= 1'b0;
  endtask

  // read and compare, data sampled in the cycle after the strobe
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1;
    chk({8'h00, rdata}, {8'h00, e});
  endtask

  // --------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------
  task automatic t_regs;
    for (int a = 8'hc8; a <= 8'hcd; a++) rc(a[7:0], 8'h00);
    wr(tmr2_pkg::ADDR_RCAP_H, 8'h5a);
    wr(8'hc7, 8'hff);
    rc(tmr2_pkg::ADDR_RCAP_H, 8'h5a);
    rc(8'hc7, 8'h00);
    $display("test regs done");
  endtask

  task automatic t_reload;
    int i;
    spd <= 1'b1;
    ien <= 1'b1;
    wr(tmr2_pkg::ADDR_RCAP_L, 8'h78);
    wr(tmr2_pkg::ADDR_RCAP_H, 8'h56);
    wr(tmr2_pkg::ADDR_CNT_L, 8'hf8);
    wr(tmr2_pkg::ADDR_CNT_H, 8'hff);
    wr(tmr2_pkg::ADDR_MODE, 8'h02);
    wr(tmr2_pkg::ADDR_CTRL, 8'h04);
    for (i = 0; i < 200 && ovf !== 1'b1; i++) @(negedge clk);
    cb(ovf, 1'b1);
    @(negedge clk);
    cb(ovff, 1'b1);
    cb(irq, 1'b1);
    cb(cko, 1'b1);
    cb(ckoe, 1'b1);
    wr(tmr2_pkg::ADDR_CTRL, 8'h80);
    rc(tmr2_pkg::ADDR_CNT_H, 8'h56);
    rc(tmr2_pkg::ADDR_CTRL, 8'h80);
    wr(tmr2_pkg::ADDR_CTRL, 8'h00);
    @(negedge clk);
    cb(irq, 1'b0);
    $display("test reload done");
  endtask

  task automatic t_baud;
    int i;
    int t0;
    wr(tmr2_pkg::ADDR_RCAP_L, 8'hf0);
    wr(tmr2_pkg::ADDR_RCAP_H, 8'hff);
    wr(tmr2_pkg::ADDR_CNT_L, 8'hf0);
    wr(tmr2_pkg::ADDR_CNT_H, 8'hff);
    wr(tmr2_pkg::ADDR_CTRL, 8'h36);
    for (i = 0; i < 200 && rxt !== 1'b1; i++) @(negedge clk);
    cb(txt, 1'b1);
    t0 = cyc;
    @(negedge clk);
    for (i = 0; i < 100 && rxt !== 1'b1; i++) @(negedge clk);
    chk(cyc[15:0] - t0[15:0], 16'h0020);
    cb(ovff, 1'b0);
    wr(tmr2_pkg::ADDR_CTRL, 8'h00);
    @(posedge clk);
    t1ovf <= 1'b1;
    @(posedge clk);
    t1ovf <= 1'b0;
    #1;
    cb(rxt, 1'b1);
    $display("test baud done");
  endtask

  task automatic t_capture;
    wr(tmr2_pkg::ADDR_CNT_L, 8'hcd);
    wr(tmr2_pkg::ADDR_CNT_H, 8'hab);
    wr(tmr2_pkg::ADDR_MODE, 8'h08);
    wr(tmr2_pkg::ADDR_CTRL, 8'h09);
    rc(tmr2_pkg::ADDR_CNT_L, 8'hcd);
    pins.pulse(1'b1, 1);
    rc(tmr2_pkg::ADDR_RCAP_L, 8'hcd);
    rc(tmr2_pkg::ADDR_RCAP_H, 8'hab);
    rc(tmr2_pkg::ADDR_CNT_H, 8'h00);
    cb(extf, 1'b1);
    cb(irq, 1'b1);
    wr(tmr2_pkg::ADDR_CTRL, 8'h01);
    pins.pulse(1'b1, 1);
    rc(tmr2_pkg::ADDR_RCAP_L, 8'hcd);
    cb(extf, 1'b0);
    $display("test capture done");
  endtask

  task automatic t_count;
    wr(tmr2_pkg::ADDR_CNT_L, 8'h00);
    wr(tmr2_pkg::ADDR_MODE, 8'h02);
    wr(tmr2_pkg::ADDR_CTRL, 8'h06);
    @(negedge clk);
    cb(ckoe, 1'b0);
    pins.pulse(1'b0, 5);
    wr(tmr2_pkg::ADDR_CTRL, 8'h00);
    rc(tmr2_pkg::ADDR_CNT_L, 8'h05);
    $display("test count done");
  endtask

  // down count with trigger low, slow prescaler, underflow period
  task automatic t_down;
    int i;
    int t0;
    spd <= 1'b0;
    wr(tmr2_pkg::ADDR_RCAP_L, 8'hfe);
    wr(tmr2_pkg::ADDR_RCAP_H, 8'hff);
    wr(tmr2_pkg::ADDR_CNT_L, 8'hff);
    wr(tmr2_pkg::ADDR_CNT_H, 8'hff);
    wr(tmr2_pkg::ADDR_MODE, 8'h01);
    pins.level(1'b0);
    wr(tmr2_pkg::ADDR_CTRL, 8'h04);
    for (i = 0; i < 100 && ovf !== 1'b1; i++) @(negedge clk);
    t0 = cyc;
    @(negedge clk);
    cb(ovff, 1'b1);
    cb(extf, 1'b1);
    for (i = 0; i < 100 && ovf !== 1'b1; i++) @(negedge clk);
    chk(cyc[15:0] - t0[15:0], 16'h0018);
    wr(tmr2_pkg::ADDR_CTRL, 8'h00);
    pins.level(1'b1);
    rc(tmr2_pkg::ADDR_CNT_H, 8'hff);
    $display("test down done");
  endtask

  task automatic t_extint;
    wr(tmr2_pkg::ADDR_MODE, 8'h10);
    @(posedge clk);
    eset <= 4'h3;
    @(posedge clk);
    eset   <= 4'h0;
    eentry <= 4'h3;
    @(posedge clk);
    eentry <= 4'h0;
    #1;
    chk({12'h000, eflag}, 16'h0002);
    $display("test extint done");
  endtask

  // --------------------------------------------------------------
  // run control
  // --------------------------------------------------------------
  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // cycle count and hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      num_errors++;
      test_done;
    end
  end

  // main sequence
  initial begin
    {rstn, wr_s, rd_s, spd, t1ovf, ien} = 6'h00;
    {addr, wdata, eset, eentry} = 24'h000000;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    t_regs;
    t_reload;
    t_baud;
    t_capture;
    t_count;
    t_down;
    t_extint;
    test_done;
  end
endmodule
`default_nettype wire
